// ===== design/sbrg_defs.vh
// Register map, fields and reset values of the rate divider
`ifndef SBRG_DEFS_VH
`define SBRG_DEFS_VH
`define SBRG_OFS_TXCS       12'h000
`define SBRG_OFS_RXCS       12'h004
`define SBRG_OFS_BAUDCTL    12'h008
`define SBRG_OFS_DIVHI      12'h00C
`define SBRG_OFS_DIVLO      12'h010
`define SBRG_OFS_STATUS     12'h014
`define SBRG_RST_TXCS       8'h02
`define SBRG_RST_RXCS       8'h00
`define SBRG_RST_BAUDCTL    8'h40
`define SBRG_RST_DIV        8'h00
`define SBRG_TXCS_WMASK     8'hFD
`define SBRG_RXCS_WMASK     8'hF9
`define SBRG_BAUDCTL_WMASK  8'hBB
`define SBRG_BIT_SYNC       4
`define SBRG_BIT_HIGH_SPEED 2
`define SBRG_BIT_WIDE       3
`define SBRG_BIT_INVERT     5
`define SBRG_PRE_64         2'h0
`define SBRG_PRE_16         2'h1
`define SBRG_PRE_4          2'h2
`define SBRG_PRE64_LAST     6'h3F
`define SBRG_PRE16_LAST     6'h0F
`define SBRG_PRE4_LAST      6'h03
`endif

// ===== design/sbrg_majority.v
// Three-sample majority filter for the serial input
`timescale 1ns/1ps
`default_nettype none
module sbrg_majority (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       sample_en,
  input  wire       din,
  output reg        level
);
  reg  [2:0] samples;
  wire       vote;

  assign vote = (samples[0] & samples[1]) | (samples[0] & samples[2]) | (samples[1] & samples[2]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samples <= 3'h7;
      level   <= 1'b1;
    end else begin
      if (sample_en) begin
        samples <= {samples[1:0], din};
      end
      level <= vote;
    end
  end
endmodule // sbrg_majority
`default_nettype wire

// ===== design/sbrg_top.v
// Rate divider with APB registers and input majority vote
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sbrg_defs.vh"
module sbrg_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        serial_input_pin,
  output reg         bit_tick,
  output reg         sample_tick,
  output wire        serial_level
);
  reg  [7:0]  transmit_control_status;
  reg  [7:0]  receive_control_status;
  reg  [7:0]  baud_control;
  reg  [7:0]  divisor_high_byte;
  reg  [7:0]  divisor_low_byte;
  reg  [15:0] div_count;
  reg  [5:0]  pre_count;
  reg         pin_meta;
  reg         pin_sync;
  reg  [1:0]  pre_sel;
  reg  [5:0]  pre_last;
  reg         addr_ok;
  wire        wr;
  wire        rd;
  wire        sync_mode;
  wire        high_speed_divider_select;
  wire        wide_divider_select;
  wire [15:0] divisor;
  wire        div_clear;
  wire        div_wrap;
  wire        pre_wrap;
  // Next-state values of the counters
  reg  [5:0]  next_pre_count;
  reg  [15:0] next_div_count;
  reg         next_bit_tick;
  reg         next_sample_tick;
  // Register hits
  wire        hit_txcs;
  wire        hit_rxcs;
  wire        hit_baudctl;
  wire        hit_divhi;
  wire        hit_divlo;
  wire        hit_status;

  // Access strobes, read data loads in the setup cycle
  assign wr        = psel & penable & pwrite;
  assign rd        = psel & ~penable & ~pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_ok;
  // Mode and divisor selection
  assign sync_mode                 = transmit_control_status[`SBRG_BIT_SYNC];
  assign high_speed_divider_select = transmit_control_status[`SBRG_BIT_HIGH_SPEED];
  assign wide_divider_select       = baud_control[`SBRG_BIT_WIDE];
  assign divisor   = wide_divider_select ? {divisor_high_byte, divisor_low_byte} : {8'h00, divisor_low_byte};
  assign div_clear = wr & (hit_divhi | hit_divlo);
  assign div_wrap  = (div_count >= divisor);
  assign pre_wrap  = (pre_count >= pre_last);

  // Address decode
  assign hit_txcs    = (paddr == `SBRG_OFS_TXCS);
  assign hit_rxcs    = (paddr == `SBRG_OFS_RXCS);
  assign hit_baudctl = (paddr == `SBRG_OFS_BAUDCTL);
  assign hit_divhi   = (paddr == `SBRG_OFS_DIVHI);
  assign hit_divlo   = (paddr == `SBRG_OFS_DIVLO);
  assign hit_status  = (paddr == `SBRG_OFS_STATUS);

  always @* begin
    addr_ok = hit_txcs | hit_rxcs | hit_baudctl | hit_divhi | hit_divlo | hit_status;
  end

  // Prescale selection from mode, width and speed
  always @* begin
    if (sync_mode) begin
      pre_sel = `SBRG_PRE_4;
    end else if (!wide_divider_select && !high_speed_divider_select) begin
      pre_sel = `SBRG_PRE_64;
    end else if (wide_divider_select && high_speed_divider_select) begin
      pre_sel = `SBRG_PRE_4;
    end else begin
      pre_sel = `SBRG_PRE_16;
    end
  end

  // Prescale end count
  always @* begin
    case (pre_sel)
      `SBRG_PRE_64: pre_last = `SBRG_PRE64_LAST;
      `SBRG_PRE_16: pre_last = `SBRG_PRE16_LAST;
      `SBRG_PRE_4:  pre_last = `SBRG_PRE4_LAST;
      default:      pre_last = `SBRG_PRE4_LAST;
    endcase
  end

  // Transmit control, ready bit forced high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_control_status <= `SBRG_RST_TXCS;
    end else if (wr && hit_txcs) begin
      transmit_control_status <= (pwdata[7:0] & `SBRG_TXCS_WMASK) | `SBRG_RST_TXCS;
    end
  end

  // Receive control, status bits read-only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_control_status <= `SBRG_RST_RXCS;
    end else if (wr && hit_rxcs) begin
      receive_control_status <= pwdata[7:0] & `SBRG_RXCS_WMASK;
    end
  end

  // Baud control, idle bit forced high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_control <= `SBRG_RST_BAUDCTL;
    end else if (wr && hit_baudctl) begin
      baud_control <= (pwdata[7:0] & `SBRG_BAUDCTL_WMASK) | `SBRG_RST_BAUDCTL;
    end
  end

  // Divisor high byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_high_byte <= `SBRG_RST_DIV;
    end else if (wr && hit_divhi) begin
      divisor_high_byte <= pwdata[7:0];
    end
  end

  // Divisor low byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_low_byte <= `SBRG_RST_DIV;
    end else if (wr && hit_divlo) begin
      divisor_low_byte <= pwdata[7:0];
    end
  end

  // Read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd) begin
      case (paddr)
        `SBRG_OFS_TXCS:    prdata <= {24'h000000, transmit_control_status};
        `SBRG_OFS_RXCS:    prdata <= {24'h000000, receive_control_status};
        `SBRG_OFS_BAUDCTL: prdata <= {24'h000000, baud_control};
        `SBRG_OFS_DIVHI:   prdata <= {24'h000000, divisor_high_byte};
        `SBRG_OFS_DIVLO:   prdata <= {24'h000000, divisor_low_byte};
        `SBRG_OFS_STATUS:  prdata <= {13'h0000, serial_level, pre_sel, div_count};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  // Next state of the prescaler and divider
  always @* begin
    next_pre_count   = pre_count;
    next_div_count   = div_count + 16'h0001;
    next_bit_tick    = 1'b0;
    next_sample_tick = 1'b0;
    if (div_clear) begin
      next_pre_count = 6'h00;
      next_div_count = 16'h0000;
    end else if (div_wrap) begin
      next_div_count   = 16'h0000;
      next_sample_tick = 1'b1;
      if (pre_wrap) begin
        next_pre_count = 6'h00;
        next_bit_tick  = 1'b1;
      end else begin
        next_pre_count = pre_count + 6'h01;
      end
    end
  end

  // Free-running counters on the device clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_count   <= 6'h00;
      div_count   <= 16'h0000;
      bit_tick    <= 1'b0;
      sample_tick <= 1'b0;
    end else begin
      pre_count   <= next_pre_count;
      div_count   <= next_div_count;
      bit_tick    <= next_bit_tick;
      sample_tick <= next_sample_tick;
    end
  end

  // Input synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= serial_input_pin;
      pin_sync <= pin_meta;
    end
  end

  // Synchronised, optionally inverted input to the vote
  sbrg_majority u_vote (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (sample_tick),
    .din       (pin_sync ^ baud_control[`SBRG_BIT_INVERT]),
    .level     (serial_level)
  );
endmodule // sbrg_top
`default_nettype wire

// ===== testbench/sbrg_checker_assertions.sv
// Port checks of the rate divider
`timescale 1ns/1ps
`default_nettype none
module sbrg_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        bit_tick,
  input wire logic        sample_tick,
  input wire logic        serial_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable;
  wire dwr = acc & pwrite & (paddr == 12'h00C || paddr == 12'h010);
  ready_high_a: assert property (pready) else $error("pready low");
  err_unmapped_a: assert property (acc && paddr > 12'h014 |-> pslverr) else $error("no error");
  err_mapped_a: assert property (acc && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad error");
  err_idle_a: assert property (!acc |-> !pslverr) else $error("error outside access");
  bit_gap_a: assert property (bit_tick |=> !bit_tick [*3]) else $error("ticks too close");
  div_clear_a: assert property (dwr |=> !bit_tick [*3]) else $error("divider not cleared");
  level_cause_a: assert property ($changed(serial_level) |-> $past(sample_tick) || $past(sample_tick, 2))
    else $error("level moved without sample");
  rd_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data moved");
  cover property (bit_tick);
  cover property (acc && pslverr);
  cover property ($fell(serial_level));
endmodule // sbrg_checker
bind sbrg_top sbrg_checker u_sbrg_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_tick(bit_tick),
  .sample_tick(sample_tick), .serial_level(serial_level));
`default_nettype wire

// ===== testbench/tb_top.sv
// Register, rate and input filter tests of the rate divider
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin = 1, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0]  rst_val [5] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00};
  wire         pready, pslverr, bit_tick, sample_tick, serial_level;
  wire  [31:0] prdata;
  int          bad_count = 0, check_count = 0, cyc = 0, c, r;
  sbrg_top u_sbrg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .serial_input_pin(pin), .bit_tick(bit_tick), .sample_tick(sample_tick), .serial_level(serial_level));
  initial forever #20 pclk = ~pclk;
  task give_verdict;
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task tick_gap(input logic s);
    c = 0;
    do begin
      @(posedge pclk);
      #1;
      c++;
    end while ((s ? sample_tick : bit_tick) !== 1'b1);
  endtask
  task level_after(input logic p, input logic exp);
    pin <= p;
    repeat (10) @(posedge pclk);
    check(serial_level, exp);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 5; i++) begin
      apb(0, 12'(i * 4), 0);
      check(rd, rst_val[i]);
    end
    apb(1, 12'h000, 32'hFF);
    apb(0, 12'h000, 0);
    check(rd, 32'hFF);
    apb(1, 12'h008, 32'hFF);
    apb(0, 12'h008, 0);
    check(rd, 32'hFB);
    apb(1, 12'h020, 32'hFF);
    check(err, 1'b1);
    apb(0, 12'h020, 0);
    check(err, 1'b1);
    check(rd, 32'h0);
    for (int m = 0; m < 8; m++) begin
      apb(1, 12'h000, 32'(m[2] * 16 + m[0] * 4));
      apb(1, 12'h008, 32'(m[1] * 8));
      apb(1, 12'h00C, 32'h01);
      apb(1, 12'h010, 32'h02);
      r = m[2] ? 4 : (m[1] && m[0]) ? 4 : (!m[1] && !m[0]) ? 64 : 16;
      tick_gap(0);
      tick_gap(0);
      check(c, r * (m[1] ? 259 : 3));
    end
    tick_gap(1);
    tick_gap(1);
    check(c, 259);
    apb(0, 12'h014, 0);
    check(rd >> 16, 32'h6);
    apb(1, 12'h000, 32'h00);
    apb(1, 12'h008, 32'h00);
    apb(1, 12'h010, 32'h00);
    level_after(0, 0);
    pin <= 1;
    @(posedge pclk);
    pin <= 0;
    repeat (8) begin
      @(posedge pclk);
      #1;
      check(serial_level, 0);
    end
    level_after(1, 1);
    apb(1, 12'h008, 32'h20);
    level_after(1, 0);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
